// ==== design/sta_pkg.sv ====
package sta_pkg;

  // ---------------------------------------------------------------------------
  // Register write port
  // ---------------------------------------------------------------------------
  localparam int         ADDR_W        = 4;
  localparam int         DATA_W        = 24;
  localparam logic [3:0] A_CFG0        = 4'h1;
  localparam logic [3:0] A_CFG1        = 4'h2;
  localparam logic [3:0] A_CFG2        = 4'h3;
  localparam logic [3:0] A_CFG3        = 4'h4;
  localparam logic [3:0] A_IRQ         = 4'h5;
  localparam logic [3:0] A_MUX         = 4'h6;
  localparam logic [3:0] A_SCAN        = 4'h7;
  localparam logic [3:0] A_TIMER       = 4'h8;
  localparam logic [3:0] A_OFFCAL      = 4'h9;
  localparam logic [3:0] A_GAINCAL     = 4'hA;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int         CFG0_MODE_LSB = 0;
  localparam int         CFG3_CONV_LSB = 6;
  localparam int         CFG3_OFFEN    = 1;
  localparam int         CFG3_GAINEN   = 0;
  localparam int         IRQ_MODE_LSB  = 2;
  localparam int         SCAN_DLY_LSB  = 21;
  localparam int         SCAN_EN_LSB   = 0;
  localparam int         N_CH          = 16;

  // ---------------------------------------------------------------------------
  // Operating states and repeat select
  // ---------------------------------------------------------------------------
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_STANDBY  = 2'h2;
  localparam logic [1:0] MODE_CONV     = 2'h3;
  localparam logic [1:0] REPEAT_CONT   = 2'h3;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  RST_MODE     = 2'h0;
  localparam logic [1:0]  RST_REPEAT   = 2'h3;
  localparam logic [15:0] RST_EN       = 16'h0000;
  localparam logic [2:0]  RST_DLY      = 3'h0;
  localparam logic [23:0] RST_TIMER    = 24'h000000;
  localparam logic [1:0]  RST_IRQM     = 2'h0;

  // ---------------------------------------------------------------------------
  // Timing counts (decimated clock periods and master clock periods)
  // ---------------------------------------------------------------------------
  localparam logic [23:0] WARMUP_PERIODS = 24'h000100;
  localparam logic [9:0]  DLY_BASE       = 10'h008;
  localparam logic [1:0]  RESTART_MCLK   = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ALIGN,
    ST_CONVERT,
    ST_INTRA,
    ST_INTER
  } sta_state_t;

endpackage

// ==== design/sta_down_counter.sv ====
module sta_down_counter
  import sta_pkg::*;
#(
  parameter int W = 24
) (
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic         clear_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_value_in,
  input  wire logic         tick_in,
  output logic      [W-1:0] count_out,
  output logic              zero_out
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // ---------------------------------------------------------------------------
  // Load, then count down once per tick until zero
  // ---------------------------------------------------------------------------
  assign count_d = clear_in ? '0 :
                   load_in  ? load_value_in :
                   (tick_in && count_q != '0) ? count_q - 1'b1 : count_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_out = count_q;
  assign zero_out  = (count_q == '0);

endmodule

// ==== design/sta_restart_align.sv ====
module sta_restart_align
  import sta_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic trigger_in,
  input  wire logic cancel_in,
  input  wire logic mclk_tick_in,
  output logic      done_out,
  output logic      busy_out
);

  logic [1:0] left_q;
  logic [1:0] left_d;

  // ---------------------------------------------------------------------------
  // Restart waits two master clock periods after the reset
  // ---------------------------------------------------------------------------
  assign done_out = (left_q == 2'h1) && mclk_tick_in && !trigger_in
                    && !cancel_in;
  assign busy_out = (left_q != 2'h0);
  assign left_d   = cancel_in  ? 2'h0 :
                    trigger_in ? RESTART_MCLK :
                    (busy_out && mclk_tick_in) ? left_q - 2'h1 : left_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      left_q <= 2'h0;
    end else begin
      left_q <= left_d;
    end
  end

endmodule

// ==== design/sta_scan_ctrl.sv ====
module sta_scan_ctrl
  import sta_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              reg_wr_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              decimated_master_clock_tick_in,
  input  wire logic              mclk_tick_in,
  input  wire logic              conv_done_in,
  output logic                   conv_reset_out,
  output logic                   conv_start_out,
  output logic                   result_update_out,
  output logic       [1:0]       adc_state_out,
  output logic       [1:0]       mode_read_out,
  output logic       [3:0]       channel_sel_out,
  output logic                   scan_active_out,
  output logic                   warmup_out
);

  // ---------------------------------------------------------------------------
  // Stored configuration
  // ---------------------------------------------------------------------------
  logic [1:0]  mode_q;
  logic [1:0]  repeat_q;
  logic [15:0] en_q;
  logic [2:0]  dly_q;
  logic [23:0] timer_q;
  logic        offen_q;
  logic        gainen_q;
  logic [1:0]  irqm_q;

  sta_state_t  st_q;
  sta_state_t  st_d;
  logic [3:0]  chan_q;
  logic [3:0]  chan_d;
  logic        full_pend_q;
  logic        full_pend_d;
  logic        start_q;
  logic        start_d;
  logic        result_q;
  logic        result_d;
  logic        reset_q;
  logic [1:0]  adc_state_q;
  logic [1:0]  adc_state_d;
  logic [1:0]  mode_read_q;
  logic        warm_q;
  logic        intra_load;
  logic        inter_load;
  logic        cnt_clear;
  logic        align_trig;
  logic        oneshot_end;

  // ---------------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------------
  wire         wr_cfg0    = reg_wr_in && (reg_addr_in == A_CFG0);
  wire         wr_cfg1    = reg_wr_in && (reg_addr_in == A_CFG1);
  wire         wr_cfg2    = reg_wr_in && (reg_addr_in == A_CFG2);
  wire         wr_cfg3    = reg_wr_in && (reg_addr_in == A_CFG3);
  wire         wr_irq     = reg_wr_in && (reg_addr_in == A_IRQ);
  wire         wr_mux     = reg_wr_in && (reg_addr_in == A_MUX);
  wire         wr_scan    = reg_wr_in && (reg_addr_in == A_SCAN);
  wire         wr_timer   = reg_wr_in && (reg_addr_in == A_TIMER);
  wire         wr_offcal  = reg_wr_in && (reg_addr_in == A_OFFCAL);
  wire         wr_gaincal = reg_wr_in && (reg_addr_in == A_GAINCAL);

  wire [1:0]   new_mode   = reg_wdata_in[CFG0_MODE_LSB +: 2];
  wire [15:0]  new_en     = reg_wdata_in[SCAN_EN_LSB +: N_CH];
  wire [2:0]   new_dly    = reg_wdata_in[SCAN_DLY_LSB +: 3];
  wire         new_offen  = reg_wdata_in[CFG3_OFFEN];
  wire         new_gainen = reg_wdata_in[CFG3_GAINEN];
  wire [1:0]   new_irqm   = reg_wdata_in[IRQ_MODE_LSB +: 2];

  wire         scan_now   = |en_q;
  wire         running    = (mode_q == MODE_CONV);
  wire         in_conv    = (st_q == ST_CONVERT) || (st_q == ST_ALIGN);

  wire         offen_chg  = wr_cfg3 && (new_offen != offen_q);
  wire         gainen_chg = wr_cfg3 && (new_gainen != gainen_q);
  // low config bit alone never restarts
  wire         irq_chg    = wr_irq && (new_irqm[1] != irqm_q[1]);

  // stop on any other state code
  wire         stop_req   = wr_cfg0 && (new_mode != MODE_CONV);

  // scan and timer writes by phase
  wire         full_req   = (wr_cfg0 && new_mode == MODE_CONV)
                         || (running && wr_scan && scan_now
                             && st_q != ST_INTER)
                         || (running && wr_scan && !scan_now
                             && new_en != 16'h0000)
                         || (running && wr_timer && scan_now
                             && st_q == ST_INTER);

  // immediate group; selector ignored when scanning
  wire         conv_src   = wr_cfg1 || wr_cfg2 || offen_chg || gainen_chg
                         || irq_chg || (wr_mux && !scan_now)
                         || (wr_offcal && offen_q)
                         || (wr_gaincal && gainen_q);
  // only the conversion under way is redone
  wire         conv_req   = running && in_conv && conv_src;

  // ---------------------------------------------------------------------------
  // Channel priority search
  // ---------------------------------------------------------------------------
  function automatic logic [4:0] next_chan(input logic [15:0] en,
                                           input logic [4:0]  below);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < N_CH; i++) begin
      if (en[i] && (5'(i) < below)) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  wire [4:0]   first_res  = next_chan(en_q, 5'h10);
  wire [4:0]   nxt_res    = next_chan(en_q, {1'b0, chan_q});
  wire [3:0]   first_idx  = first_res[3:0];
  wire         nxt_found  = nxt_res[4];
  wire [3:0]   nxt_idx    = nxt_res[3:0];

  // ---------------------------------------------------------------------------
  // Delay and interval counters
  // ---------------------------------------------------------------------------
  logic [9:0]  intra_cnt;
  logic        intra_zero;
  logic [23:0] inter_cnt;
  logic        inter_zero;
  logic        align_done;
  logic        align_busy;

  // delay length from the select code
  wire [9:0]   dly_len    = (dly_q == 3'h0) ? 10'h000 :
                            DLY_BASE << (dly_q - 3'h1);

  // both tick on the decimated clock
  sta_down_counter #(.W(10)) u_intra (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .clear_in      (cnt_clear),
    .load_in       (intra_load),
    .load_value_in (dly_len),
    .tick_in       (decimated_master_clock_tick_in),
    .count_out     (intra_cnt),
    .zero_out      (intra_zero)
  );

  sta_down_counter #(.W(24)) u_inter (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .clear_in      (cnt_clear),
    .load_in       (inter_load),
    .load_value_in (timer_q),
    .tick_in       (decimated_master_clock_tick_in),
    .count_out     (inter_cnt),
    .zero_out      (inter_zero)
  );

  sta_restart_align u_align (
    .clk_in       (clk_in),
    .reset_n_in   (reset_n_in),
    .trigger_in   (align_trig),
    .cancel_in    (stop_req),
    .mclk_tick_in (mclk_tick_in),
    .done_out     (align_done),
    .busy_out     (align_busy)
  );

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    chan_d      = chan_q;
    full_pend_d = full_pend_q;
    start_d     = 1'b0;
    result_d    = 1'b0;
    intra_load  = 1'b0;
    inter_load  = 1'b0;
    cnt_clear   = 1'b0;
    align_trig  = 1'b0;
    oneshot_end = 1'b0;
    if (stop_req) begin
      st_d        = ST_IDLE;
      full_pend_d = 1'b0;
      cnt_clear   = 1'b0;
    end else if (full_req) begin
      st_d        = ST_ALIGN;
      full_pend_d = 1'b1;
      align_trig  = 1'b1;
      cnt_clear   = 1'b1;
    end else if (conv_req) begin
      st_d        = ST_ALIGN;
      align_trig  = 1'b1;
    end else begin
      case (st_q)
        ST_IDLE: begin
          st_d = ST_IDLE;
        end
        ST_ALIGN: begin
          if (align_done) begin
            st_d        = ST_CONVERT;
            start_d     = 1'b1;
            full_pend_d = 1'b0;
            // whole cycle restarts from the first channel
            if (full_pend_q) begin
              chan_d = first_idx;
            end
          end
        end
        ST_CONVERT: begin
          if (conv_done_in) begin
            result_d = 1'b1;
            if (scan_now && nxt_found) begin
              // selector moves as the delay begins
              chan_d = nxt_idx;
              if (dly_q == 3'h0) begin
                start_d = 1'b1;
              end else begin
                intra_load = 1'b1;
                st_d       = ST_INTRA;
              end
            end else begin
              if (scan_now) begin
                chan_d = first_idx;
              end
              if (repeat_q != REPEAT_CONT) begin
                st_d        = ST_IDLE;
                oneshot_end = 1'b1;
              end else if (scan_now && timer_q != 24'h000000) begin
                inter_load = 1'b1;
                st_d       = ST_INTER;
              end else begin
                start_d = 1'b1;
              end
            end
          end
        end
        ST_INTRA: begin
          if (intra_zero) begin
            st_d    = ST_CONVERT;
            start_d = 1'b1;
          end
        end
        ST_INTER: begin
          // launch when the count reaches zero
          if (inter_zero) begin
            st_d    = ST_CONVERT;
            start_d = 1'b1;
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Applied converter state
  // ---------------------------------------------------------------------------
  // shutdown only above warm-up time; equal stays standby
  wire         shut_case  = (timer_q > WARMUP_PERIODS);
  // warm-up from a count of 256 down
  wire         warming    = (st_q == ST_INTER) && shut_case
                            && (inter_cnt <= WARMUP_PERIODS);

  always_comb begin
    case (st_q)
      ST_IDLE: begin
        adc_state_d = running ? MODE_STANDBY : mode_q;
      end
      ST_INTRA: begin
        adc_state_d = MODE_STANDBY;
      end
      ST_INTER: begin
        adc_state_d = !shut_case ? MODE_STANDBY :
                      warming    ? MODE_CONV    : MODE_SHUTDOWN;
      end
      default: begin
        adc_state_d = MODE_CONV;
      end
    endcase
  end

  // state field read back as 11 during scanning
  wire [1:0]   mode_read_d = (scan_now && st_q != ST_IDLE) ? MODE_CONV :
                             mode_q;

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q   <= RST_MODE;
      repeat_q <= RST_REPEAT;
      en_q     <= RST_EN;
      dly_q    <= RST_DLY;
      timer_q  <= RST_TIMER;
      offen_q  <= 1'b0;
      gainen_q <= 1'b0;
      irqm_q   <= RST_IRQM;
    end else begin
      if (wr_cfg0) begin
        mode_q <= new_mode;
      end else if (oneshot_end) begin
        mode_q <= MODE_STANDBY;
      end
      if (wr_cfg3) begin
        repeat_q <= reg_wdata_in[CFG3_CONV_LSB +: 2];
        offen_q  <= new_offen;
        gainen_q <= new_gainen;
      end
      if (wr_irq) begin
        irqm_q <= new_irqm;
      end
      // delay select stored but only used while scanning
      if (wr_scan) begin
        en_q  <= new_en;
        dly_q <= new_dly;
      end
      if (wr_timer) begin
        timer_q <= reg_wdata_in;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer state and outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q        <= ST_IDLE;
      chan_q      <= 4'h0;
      full_pend_q <= 1'b0;
      start_q     <= 1'b0;
      result_q    <= 1'b0;
      reset_q     <= 1'b0;
      adc_state_q <= RST_MODE;
      mode_read_q <= RST_MODE;
      warm_q      <= 1'b0;
    end else begin
      st_q        <= st_d;
      chan_q      <= chan_d;
      full_pend_q <= full_pend_d;
      start_q     <= start_d;
      result_q    <= result_d;
      reset_q     <= stop_req || full_req || conv_req;
      adc_state_q <= adc_state_d;
      mode_read_q <= mode_read_d;
      warm_q      <= warming;
    end
  end

  assign conv_reset_out    = reset_q;
  assign conv_start_out    = start_q;
  assign result_update_out = result_q;
  assign adc_state_out     = adc_state_q;
  assign mode_read_out     = mode_read_q;
  assign channel_sel_out   = chan_q;
  assign scan_active_out   = scan_now;
  assign warmup_out        = warm_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_mid_done;
    st_q == ST_CONVERT && conv_done_in && scan_now && nxt_found
    && !stop_req && !full_req && !conv_req;
  endsequence

  sequence s_last_done;
    st_q == ST_CONVERT && conv_done_in && scan_now && !nxt_found
    && !stop_req && !full_req && !conv_req;
  endsequence

  AST_DLY_LEN: assert property (
    s_mid_done ##1 (st_q == ST_INTRA) |->
      intra_cnt == ((dly_q == 3'h1) ? 10'h008 :
                    (dly_q == 3'h2) ? 10'h010 :
                    (dly_q == 3'h3) ? 10'h020 :
                    (dly_q == 3'h4) ? 10'h040 :
                    (dly_q == 3'h5) ? 10'h080 :
                    (dly_q == 3'h6) ? 10'h100 : 10'h200))
    else $error("intra delay length wrong");

  AST_NO_END_DELAY: assert property (
    s_last_done |=> st_q != ST_INTRA)
    else $error("delay inserted at cycle end");

  AST_INTRA_STANDBY: assert property (
    (st_q == ST_INTRA) ##1 (st_q == ST_INTRA) |->
      adc_state_out == 2'h2 && mode_q == 2'h3)
    else $error("not standby during intra delay");

  AST_CHAN_STEP: assert property (
    s_mid_done |=> channel_sel_out == $past(nxt_idx))
    else $error("selector did not switch");

  AST_INTER_LOAD: assert property (
    s_last_done ##1 (st_q == ST_INTER) |-> inter_cnt == timer_q)
    else $error("interval not loaded");

  AST_SHUTDOWN: assert property (
    (st_q == ST_INTER && timer_q > 24'h000100
     && inter_cnt > 24'h000100) [*2] |-> adc_state_out == 2'h0)
    else $error("no shutdown between cycles");

  AST_SHORT_STANDBY: assert property (
    (st_q == ST_INTER && timer_q <= 24'h000100) [*2] |->
      adc_state_out == 2'h2)
    else $error("no standby on short interval");

  AST_READ_11: assert property (
    (scan_now && st_q != ST_IDLE) |=> mode_read_out == 2'h3)
    else $error("state field not read as 11");

  AST_IMM_RESET: assert property (
    (running && in_conv && wr_cfg1) |=>
      conv_reset_out && st_q == ST_ALIGN)
    else $error("immediate group write not reset");

  AST_RESTART_WAIT: assert property (
    (st_q == ST_ALIGN) |-> align_busy && !conv_start_out)
    else $error("restart issued before alignment");

  AST_STOP: assert property (
    (wr_cfg0 && new_mode != 2'h3) |=>
      st_q == ST_IDLE && conv_reset_out)
    else $error("stop write did not stop");

endmodule

// ==== testbench/sta_conv_model.sv ====
module sta_conv_model #(
  parameter int LAT = 20
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic start_in,
  input  wire logic reset_in,
  output logic      done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_q;
  // Converter answers a start after LAT cycles; a reset cancels it
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 0;
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt_q == 1) && !reset_in;
      cnt_q <= reset_in ? 0 : start_in ? LAT : (cnt_q > 0) ? cnt_q - 1 : 0;
    end
  end
endmodule

// ==== testbench/tb_scan_timing_and_auto_restart.sv ====
module tb_scan_timing_and_auto_restart;
  import sta_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [23:0] wdata = 24'h000000;
  logic [1:0]  tk = 2'h0;
  logic [1:0]  st, rd;
  logic [3:0]  chan;
  logic        done, crst, cstart, upd, act, warm, seen;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          n;
  always #25 clk_in = ~clk_in;
  // Decimated tick every 4 cycles, master tick every 2
  always @(posedge clk_in) #5 tk <= tk + 2'h1;
  sta_scan_ctrl u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .decimated_master_clock_tick_in(tk == 2'h0), .mclk_tick_in(tk[0]),
    .conv_done_in(done), .conv_reset_out(crst), .conv_start_out(cstart),
    .result_update_out(upd), .adc_state_out(st), .mode_read_out(rd),
    .channel_sel_out(chan), .scan_active_out(act), .warmup_out(warm));
  sta_conv_model u_conv (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .start_in(cstart), .reset_in(crst), .done_out(done));
  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_in);
    #5 wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk_in);
    #5 wr = 1'b0;
    seen = crst;
    @(posedge clk_in);
    #1 seen = seen | crst;
  endtask
  // Waits on start (0), result (1) or warm-up (2); n counts cycles
  task wt(input int k);
    n = 0;
    while (n < 3000 && (k == 0 ? cstart : k == 1 ? upd : warm) !== 1'b1)
    begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n == 3000) chk(8'h0, 8'h1);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    #5 reset_n_in = 1'b1;
    chk(8'({act, st, rd}), 8'h00);
    wr_reg(A_TIMER, 24'd300);
    chk(8'(seen), 8'h0);
    wr_reg(A_SCAN, 24'h208001);
    chk(8'(act), 8'h1);
    wr_reg(A_CFG0, 24'h000003);
    chk(8'({seen, rd}), 8'h7);
    wt(0);
    chk(8'(chan), 8'hF);
    $display("scan start test done");
    wr_reg(A_CFG3, 24'h0000C0);
    chk(8'(seen), 8'h0);
    wr_reg(A_CFG1, 24'h000001);
    chk(8'(seen), 8'h1);
    wt(0);
    chk(8'({n < 12, chan}), 8'h1F);
    wr_reg(A_MUX, 24'h000005);
    chk(8'(seen), 8'h0);
    wr_reg(A_OFFCAL, 24'h000010);
    chk(8'(seen), 8'h0);
    $display("restart test done");
    wt(1);
    @(posedge clk_in);
    #1 chk(8'({chan, st, rd}), 8'h0B);
    wt(0);
    chk(8'(n >= 28 && n <= 36), 8'h1);
    wt(1);
    @(posedge clk_in);
    #1 chk(8'({st, rd}), 8'h3);
    wt(2);
    chk(8'({st, rd}), 8'hF);
    wt(0);
    chk(8'({chan, rd}), 8'h3F);
    wr_reg(A_TIMER, 24'd20);
    chk(8'(seen), 8'h0);
    wt(0);
    wt(1);
    @(posedge clk_in);
    #1 chk(8'({st, rd}), 8'hB);
    $display("interval test done");
    wr_reg(A_CFG0, 24'h000000);
    chk(8'({seen, rd}), 8'h4);
    $display("stop test done");
    stop_test();
  end
  initial begin
    #500000;
    mismatches++;
    stop_test();
  end
endmodule
